// ==== rtl/fxref_ctrl.sv ====
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module fxref_ctrl (
  input  wire logic                          CLK,
  input  wire logic                          RSTN,
  input  wire logic [fxref_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [fxref_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                          WR_STB,
  input  wire logic                          RD_STB,
  output var  logic [fxref_pkg::DATA_W-1:0]  RDATA,
  output var  logic                          REF_ENABLE,
  output var  logic                          REF_READY,
  output var  logic                          TEMP_SENSE_ENABLE,
  output var  logic                          TEMP_SENSE_RANGE_SELECT,
  output var  logic [1:0]                    CMP_DAC_GAIN_SELECT,
  output var  logic [1:0]                    ADC_GAIN_SELECT,
  output var  logic                          CMP_DAC_BUF_ON,
  output var  logic [2:0]                    CMP_DAC_GAIN_ONEHOT,
  output var  logic                          ADC_BUF_ON,
  output var  logic [2:0]                    ADC_GAIN_ONEHOT
);
  import fxref_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] ctrl_next;
  logic              ready_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] ctrl_view;
  logic              hit;
  logic              wr_hit;
  logic              rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: only the control offset is mapped.
  assign hit    = (ADDR == FXREF_CTRL_OFFSET);
  assign wr_hit = WR_STB && hit;
  assign rd_hit = RD_STB && hit;

  // The value software sees: stored fields with the ready bit forced in.
  always_comb begin
    ctrl_view                = ctrl_reg;
    ctrl_view[REF_READY_BIT] = ready_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next value of the stored fields; the ready position never stores.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_hit) begin
      ctrl_next = WDATA & FXREF_CTRL_WMASK;
    end
  end

  // Control register, cleared to zero by reset.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= FXREF_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Ready indication; it settles at once and reads one in every state.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ready_reg <= REF_READY_VALUE;
    end else begin
      ready_reg <= REF_READY_VALUE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data stand for the one cycle after the strobe, else zero.
  always_comb begin
    rdata_next = FXREF_UNMAPPED_RD;
    if (rd_hit) begin
      rdata_next = ctrl_view;
    end
  end

  // Read data register.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= FXREF_UNMAPPED_RD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two separate buffer paths, each decoded from its own field.
  fxref_gain_buf u_cmp_dac_buf (
    .clk             (CLK),
    .rstn            (RSTN),
    .gain_sel        (ctrl_reg[CMP_DAC_GAIN_HI:CMP_DAC_GAIN_LO]),
    .buf_on_reg      (CMP_DAC_BUF_ON),
    .gain_onehot_reg (CMP_DAC_GAIN_ONEHOT)
  );

  fxref_gain_buf u_adc_buf (
    .clk             (CLK),
    .rstn            (RSTN),
    .gain_sel        (ctrl_reg[ADC_GAIN_HI:ADC_GAIN_LO]),
    .buf_on_reg      (ADC_BUF_ON),
    .gain_onehot_reg (ADC_GAIN_ONEHOT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from a register bit.
  assign RDATA                   = rdata_reg;
  assign REF_ENABLE              = ctrl_reg[REF_ENABLE_BIT];
  assign REF_READY               = ready_reg;
  assign TEMP_SENSE_ENABLE       = ctrl_reg[TEMP_ENABLE_BIT];
  assign TEMP_SENSE_RANGE_SELECT = ctrl_reg[TEMP_RANGE_BIT];
  assign CMP_DAC_GAIN_SELECT     = ctrl_reg[CMP_DAC_GAIN_HI:CMP_DAC_GAIN_LO];
  assign ADC_GAIN_SELECT         = ctrl_reg[ADC_GAIN_HI:ADC_GAIN_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register behaviour.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  // Expected one-hot buffer word of a gain code, spelled out from the code table.
  function automatic logic [2:0] exp_onehot(input logic [1:0] code);
    logic [2:0] oh;
    oh = {code == 2'h3, code == 2'h2, code == 2'h1};
    return oh;
  endfunction

  // The enable follows the written bit on the next edge.
  AST_REF_ENABLE_WRITE: assert property (
    wr_hit |=> (REF_ENABLE == $past(WDATA[REF_ENABLE_BIT]))
  ) else $error("Reference enable did not follow the write.");

  // Without a write the enable holds its value.
  AST_REF_ENABLE_HOLD: assert property (
    !wr_hit |=> $stable(REF_ENABLE)
  ) else $error("Reference enable changed without a write.");

  // A read of the register shows the ready bit set.
  AST_READY_READBACK: assert property (
    rd_hit |=> RDATA[REF_READY_BIT]
  ) else $error("Ready bit read back as zero.");

  // The ready output stays high whatever the enable does.
  AST_READY_ALWAYS: assert property (
    REF_READY && $past(REF_READY)
  ) else $error("Ready output dropped.");

  // Temperature indicator enable follows its written bit.
  AST_TEMP_ENABLE: assert property (
    wr_hit |=> (TEMP_SENSE_ENABLE == $past(WDATA[TEMP_ENABLE_BIT]))
  ) else $error("Temperature enable did not follow the write.");

  // Range select follows its written bit.
  AST_TEMP_RANGE: assert property (
    wr_hit |=> (TEMP_SENSE_RANGE_SELECT == $past(WDATA[TEMP_RANGE_BIT]))
  ) else $error("Temperature range did not follow the write.");

  // Comparator/DAC buffer shows the decoded gain two edges after a write.
  AST_CMP_DAC_GAIN: assert property (
    wr_hit ##1 !wr_hit |=>
      (CMP_DAC_GAIN_ONEHOT ==
         exp_onehot($past(WDATA[CMP_DAC_GAIN_HI:CMP_DAC_GAIN_LO], 2)))
      && (CMP_DAC_BUF_ON ==
         ($past(WDATA[CMP_DAC_GAIN_HI:CMP_DAC_GAIN_LO], 2) != 2'h0))
  ) else $error("Comparator/DAC buffer gain wrong after write.");

  // Converter buffer shows the decoded gain two edges after a write.
  AST_ADC_GAIN: assert property (
    wr_hit ##1 !wr_hit |=>
      (ADC_GAIN_ONEHOT == exp_onehot($past(WDATA[ADC_GAIN_HI:ADC_GAIN_LO], 2)))
      && (ADC_BUF_ON == ($past(WDATA[ADC_GAIN_HI:ADC_GAIN_LO], 2) != 2'h0))
  ) else $error("Converter buffer gain wrong after write.");

  // A change of the comparator/DAC field leaves the converter buffer untouched.
  AST_PATHS_INDEPENDENT: assert property (
    $stable(ADC_GAIN_SELECT) && $changed(CMP_DAC_GAIN_SELECT) |=> $stable(ADC_GAIN_ONEHOT)
  ) else $error("Converter buffer moved on a comparator field change.");

  // Read data equal the register view in the cycle after a mapped read.
  AST_READBACK: assert property (
    rd_hit && !$past(wr_hit) |=> (RDATA == ($past(WDATA & FXREF_CTRL_WMASK, 2) |
      8'h40)) or (RDATA == {ctrl_reg[7], 1'h1, ctrl_reg[5:0]})
  ) else $error("Read data do not match the register.");

  // Unmapped reads and idle cycles return zero.
  AST_UNMAPPED_ZERO: assert property (
    !rd_hit |=> (RDATA == FXREF_UNMAPPED_RD)
  ) else $error("Read data not zero outside a mapped read.");

  // Writing a one to the ready position stores nothing there.
  AST_READY_WRITE_IGNORED: assert property (
    wr_hit ##1 rd_hit |=>
      (RDATA[REF_READY_BIT]) && (ctrl_reg[REF_READY_BIT] == 1'h0)
  ) else $error("Ready position took a written value.");

  // The write just taken shows back on an immediate read.
  AST_WRITE_THEN_READ: assert property (
    wr_hit ##1 (rd_hit && !wr_hit) |=>
      (RDATA == (($past(WDATA, 2) & FXREF_CTRL_WMASK) | 8'h40))
  ) else $error("Immediate read-back mismatch.");

  // Reset holds every stored field at zero and the ready output high.
  AST_RESET_STATE: assert property (
    disable iff (1'h0)
    !RSTN ##1 !RSTN |->
      (ctrl_reg == FXREF_CTRL_RESET) && REF_READY && (RDATA == FXREF_UNMAPPED_RD)
      && !CMP_DAC_BUF_ON && !ADC_BUF_ON
  ) else $error("Register state not cleared during reset.");

  // Temperature indicator enable holds without a write.
  AST_TEMP_ENABLE_HOLD: assert property (
    !wr_hit |=>
      $stable(TEMP_SENSE_ENABLE)
  ) else $error("Temperature enable changed without a write.");

  // Range select holds without a write.
  AST_TEMP_RANGE_HOLD: assert property (
    !wr_hit |=>
      $stable(TEMP_SENSE_RANGE_SELECT)
  ) else $error("Temperature range changed without a write.");

  // Comparator/DAC gain field follows its written bits.
  AST_CMP_DAC_SELECT: assert property (
    wr_hit |=>
      (CMP_DAC_GAIN_SELECT == $past(WDATA[CMP_DAC_GAIN_HI:CMP_DAC_GAIN_LO]))
  ) else $error("Comparator/DAC gain field did not follow the write.");

  // Converter gain field follows its written bits.
  AST_ADC_SELECT: assert property (
    wr_hit |=>
      (ADC_GAIN_SELECT == $past(WDATA[ADC_GAIN_HI:ADC_GAIN_LO]))
  ) else $error("Converter gain field did not follow the write.");

  // Comparator/DAC gain field holds without a write.
  AST_CMP_DAC_HOLD: assert property (
    !wr_hit |=>
      $stable(CMP_DAC_GAIN_SELECT)
  ) else $error("Comparator/DAC gain field changed without a write.");

  // Converter gain field holds without a write.
  AST_ADC_HOLD: assert property (
    !wr_hit |=>
      $stable(ADC_GAIN_SELECT)
  ) else $error("Converter gain field changed without a write.");

  // A change of the converter field leaves the comparator/DAC buffer untouched.
  AST_PATHS_INDEPENDENT_REV: assert property (
    $stable(CMP_DAC_GAIN_SELECT) && $changed(ADC_GAIN_SELECT) |=>
      $stable(CMP_DAC_GAIN_ONEHOT)
  ) else $error("Comparator/DAC buffer moved on a converter field change.");

  // The comparator/DAC buffer never selects two gains and is on only with a gain.
  AST_CMP_DAC_SHAPE: assert property (
    $onehot0(CMP_DAC_GAIN_ONEHOT)
      && (CMP_DAC_BUF_ON == (CMP_DAC_GAIN_ONEHOT != 3'h0))
  ) else $error("Comparator/DAC buffer controls inconsistent.");

  // The converter buffer never selects two gains and is on only with a gain.
  AST_ADC_SHAPE: assert property (
    $onehot0(ADC_GAIN_ONEHOT)
      && (ADC_BUF_ON == (ADC_GAIN_ONEHOT != 3'h0))
  ) else $error("Converter buffer controls inconsistent.");

  // A one written to the ready position is never stored.
  AST_READY_NOT_STORED: assert property (
    wr_hit && WDATA[REF_READY_BIT] |=>
      !ctrl_reg[REF_READY_BIT]
  ) else $error("Ready position stored a written one.");

  // A write to any other address leaves the register alone.
  AST_UNMAPPED_WRITE: assert property (
    WR_STB && !hit |=>
      $stable(ctrl_reg)
  ) else $error("Unmapped write changed the register.");

  // Without a mapped write the register keeps its value.
  AST_CTRL_HOLD: assert property (
    !wr_hit |=>
      $stable(ctrl_reg)
  ) else $error("Register changed without a mapped write.");

  // Read data show the stored fields with the ready bit set.
  AST_READ_VIEW: assert property (
    rd_hit |=>
      (RDATA == (($past(ctrl_reg) & FXREF_CTRL_WMASK) | 8'h40))
  ) else $error("Read data differ from the stored fields.");

  // Main scenarios.
  COV_ENABLE_ON: cover property (wr_hit && WDATA[REF_ENABLE_BIT] ##1 REF_ENABLE);
  COV_PATHS_APART: cover property (CMP_DAC_BUF_ON && !ADC_BUF_ON);
  COV_BOTH_4X: cover property (ADC_GAIN_ONEHOT == 3'h4 && CMP_DAC_GAIN_ONEHOT == 3'h4);
  COV_WRITE_READ: cover property (wr_hit ##1 rd_hit);
  COV_UNMAPPED_READ: cover property (RD_STB && !hit);

endmodule

`default_nettype wire

// ==== rtl/fxref_gain_buf.sv ====
`timescale 1ns/1ps
`default_nettype none

module fxref_gain_buf (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [1:0]                 gain_sel,
  output var  logic                       buf_on_reg,
  output var  logic [2:0]                 gain_onehot_reg
);
  import fxref_pkg::*;

  logic       buf_on_next;
  logic [2:0] gain_onehot_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decodes the gain code of one path; code zero leaves the buffer off.
  always_comb begin
    gain_onehot_next = fxref_gain_onehot(gain_sel);
    buf_on_next      = (fxref_gain_t'(gain_sel) != GAIN_OFF);
  end

  // Registers the decoded buffer controls so the analog side sees clean levels.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_on_reg      <= 1'h0;
      gain_onehot_reg <= 3'h0;
    end else begin
      buf_on_reg      <= buf_on_next;
      gain_onehot_reg <= gain_onehot_next;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/fxref_pkg.sv ====
// Functional notes
// - Enable bit 7 turns the reference on.
// - Bit 6 reports reference settled and ready.
// - Ready flag always reads back as one.
// - Bit 5 enables the die temperature indicator.
// - Bit 4 picks indicator high or low range.
// - Bits 3:2 set comparator/DAC buffer gain.
// - Bits 1:0 set converter buffer gain.
// - Both gain paths are configured independently.
// - 8-bit register at 0x90C, clears to zero.
`default_nettype none

package fxref_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [ADDR_W-1:0] FXREF_CTRL_OFFSET = 12'h90C;
  localparam logic [DATA_W-1:0] FXREF_CTRL_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] FXREF_UNMAPPED_RD = 8'h00;

  // Field positions inside the control register.
  localparam int REF_ENABLE_BIT    = 7;
  localparam int REF_READY_BIT     = 6;
  localparam int TEMP_ENABLE_BIT   = 5;
  localparam int TEMP_RANGE_BIT    = 4;
  localparam int CMP_DAC_GAIN_HI   = 3;
  localparam int CMP_DAC_GAIN_LO   = 2;
  localparam int ADC_GAIN_HI       = 1;
  localparam int ADC_GAIN_LO       = 0;

  // Mask of the bits that software may change.
  localparam logic [DATA_W-1:0] FXREF_CTRL_WMASK = 8'hBF;

  // The ready indication on this family is hard-wired high.
  localparam logic REF_READY_VALUE = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer gain settings of one amplifier path.
  typedef enum logic [1:0] {
    GAIN_OFF = 2'h0,
    GAIN_1X  = 2'h1,
    GAIN_2X  = 2'h2,
    GAIN_4X  = 2'h3
  } fxref_gain_t;

  // Turns a gain code into a one-hot word: bit 0 is 1x, 1 is 2x, 2 is 4x.
  function automatic logic [2:0] fxref_gain_onehot(input logic [1:0] sel);
    logic [2:0] oh;
    oh = 3'h0;
    case (fxref_gain_t'(sel))
      GAIN_1X: oh = 3'h1;
      GAIN_2X: oh = 3'h2;
      GAIN_4X: oh = 3'h4;
      default: oh = 3'h0;
    endcase
    return oh;
  endfunction

endpackage

`default_nettype wire

// ==== sim/fxref_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fxref_pkg::*;

  logic              clk;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_stb;
  logic              rd_stb;
  logic [DATA_W-1:0] rdata;
  logic              ref_en;
  logic              ref_rdy;
  logic              ts_en;
  logic              ts_rng;
  logic [1:0]        cmp_sel;
  logic [1:0]        adc_sel;
  logic              cmp_on;
  logic              adc_on;
  logic [2:0]        cmp_oh;
  logic [2:0]        adc_oh;
  logic [7:0]        v;
  int                num_errors;
  int                tests_run;

  fxref_ctrl i_fxref_ctrl (
    .CLK                     (clk),
    .RSTN                    (rstn),
    .ADDR                    (addr),
    .WDATA                   (wdata),
    .WR_STB                  (wr_stb),
    .RD_STB                  (rd_stb),
    .RDATA                   (rdata),
    .REF_ENABLE              (ref_en),
    .REF_READY               (ref_rdy),
    .TEMP_SENSE_ENABLE       (ts_en),
    .TEMP_SENSE_RANGE_SELECT (ts_rng),
    .CMP_DAC_GAIN_SELECT     (cmp_sel),
    .ADC_GAIN_SELECT         (adc_sel),
    .CMP_DAC_BUF_ON          (cmp_on),
    .CMP_DAC_GAIN_ONEHOT     (cmp_oh),
    .ADC_BUF_ON              (adc_on),
    .ADC_GAIN_ONEHOT         (adc_oh)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 25 ns period.
  always #12.5 clk = ~clk;

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks are entered just after a rising edge and return on one.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask

  // Read data are taken in the single cycle after the strobe.
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // Field outputs packed in register order.
  function automatic logic [7:0] fields();
    return {ref_en, ref_rdy, ts_en, ts_rng, cmp_sel, adc_sel};
  endfunction

  // Expected buffer-on and one-hot gain word of one path.
  function automatic logic [3:0] dec(input logic [1:0] c);
    return {c != 2'h0, c == 2'h3, c == 2'h2, c == 2'h1};
  endfunction

  // Writes the register, then checks fields and the decoded outputs a cycle later.
  task automatic wr_check(input logic [7:0] d);
    wr(FXREF_CTRL_OFFSET, d);
    @(negedge clk);
    check("fields", fields(), (d & 8'hBF) | 8'h40);
    @(negedge clk);
    check("decoded", {cmp_on, cmp_oh, adc_on, adc_oh}, {dec(d[3:2]), dec(d[1:0])});
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset state of every output and of the register.
  task automatic test_reset();
    @(negedge clk);
    check("reset_fields", fields(), 8'h40);
    check("reset_decoded", {cmp_on, cmp_oh, adc_on, adc_oh}, 8'h00);
    @(posedge clk);
    rd(FXREF_CTRL_OFFSET, v);
    check("reset_read", v, 8'h40);
    $display("test reset done");
  endtask

  // Every gain pair on both paths, with all upper bits swept, read back each time.
  task automatic test_fields();
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      d = 8'((i << 4) | (15 - i));
      wr_check(d);
      rd(FXREF_CTRL_OFFSET, v);
      check("readback", v, (d & 8'hBF) | 8'h40);
    end
    $display("test fields done");
  endtask

  // Write and read back to back, then read data return to zero.
  task automatic test_b2b();
    wr(FXREF_CTRL_OFFSET, 8'h8E);
    rd(FXREF_CTRL_OFFSET, v);
    check("b2b_read", v, 8'hCE);
    @(negedge clk);
    check("rdata_idle", rdata, 8'h00);
    @(posedge clk);
    $display("test back to back done");
  endtask

  // Writes to neighbouring and aliased addresses leave the register alone.
  // The first write keeps the converter field and moves the comparator field, the enable and both indicator bits.
  task automatic test_unmapped();
    logic [11:0] bad [3] = '{12'h90B, 12'h90D, 12'h10C};
    wr_check(8'h36);
    foreach (bad[k]) begin
      wr(bad[k], 8'hFF);
      @(negedge clk);
      check("unmapped_fields", fields(), 8'h76);
      @(posedge clk);
      rd(bad[k], v);
      check("unmapped_read", v, 8'h00);
    end
    $display("test unmapped done");
  endtask

  // Reset in mid-run clears everything at once.
  task automatic test_mid_reset();
    wr(FXREF_CTRL_OFFSET, 8'hFF);
    rstn <= 1'h0;
    @(negedge clk);
    check("midreset_fields", fields(), 8'h40);
    check("midreset_decoded", {cmp_on, cmp_oh, adc_on, adc_oh}, 8'h00);
    @(posedge clk);
    rstn <= 1'h1;
    rd(FXREF_CTRL_OFFSET, v);
    check("midreset_read", v, 8'h40);
    $display("test mid reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    clk        = 1'h0;
    rstn       = 1'h0;
    addr       = 12'h000;
    wdata      = 8'h00;
    wr_stb     = 1'h0;
    rd_stb     = 1'h0;
    num_errors = 0;
    tests_run  = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    test_reset();
    test_fields();
    test_b2b();
    test_unmapped();
    test_mid_reset();
    final_report();
  end

  // Watchdog well beyond the roughly 120 cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end

endmodule

`default_nettype wire
